// file: design/epfo_consts.vh
`ifndef EPFO_CONSTS_VH
`define EPFO_CONSTS_VH
// Oscillator rate in Hz and clock period in ns
`define EPFO_CLK_HZ         10000000
`define EPFO_CLK_NS         100
// Base rate divider exponents per rate-select code
`define EPFO_DIV_EXP_00     19
`define EPFO_DIV_EXP_01     18
`define EPFO_DIV_EXP_10     17
`define EPFO_DIV_EXP_11     16
// Full-scale slow-output factor 0.204, in 1/1000 units
`define EPFO_FS_MILLI       204
// Transfer constant 515.84, in 1/100 units
`define EPFO_XFER_CENTI     51584
// Slow pulse period limit and calibration pulse width, in ms
`define EPFO_SLOW_MAX_MS    1062
`define EPFO_CAL_WIDTH_MS   173
`define EPFO_CAL_PER_MS     346
// High-rate calibration pulse width, in ns
`define EPFO_HR_WIDTH_NS    35000
// Creep threshold 0.0014 %, in parts per 10^7
`define EPFO_CREEP_PP10M    140
// Calibration multiples (log2)
`define EPFO_CAL_LOG_128    7
`define EPFO_CAL_LOG_HR     11
// Timing counts derived from the clock rate
`define EPFO_SLOW_MAX_CYC   ((`EPFO_SLOW_MAX_MS * 1000000) / `EPFO_CLK_NS)
`define EPFO_CAL_WIDTH_CYC  ((`EPFO_CAL_WIDTH_MS * 1000000) / `EPFO_CLK_NS)
`define EPFO_HR_WIDTH_CYC   ((`EPFO_HR_WIDTH_NS + `EPFO_CLK_NS - 1) / `EPFO_CLK_NS)
`endif

// file: design/epfo_pulse_shaper.v
`include "epfo_consts.vh"
// Turns a one-cycle event into a pulse of width min(cap, period/2), or of width cap when i_fixed is set
module epfo_pulse_shaper #(
   parameter CW = 28
) (
   // Clock and reset
   input  wire          i_clock,
   input  wire          i_nrst,
   // Control
   input  wire          i_event,
   input  wire [CW-1:0] i_cap,
   input  wire          i_fixed,
   // Pulse
   output wire          o_active
);
   reg [CW-1:0] period_ff;
   reg [CW-1:0] last_per_ff;
   reg [CW-1:0] width_ff;
   reg [CW-1:0] nxt_width;
   reg          run_ff;
   always @* begin
      // Half the last period when the period is short, else the cap
      nxt_width = i_cap;
      if (!i_fixed && ({1'b0, period_ff} < {i_cap, 1'b0}))
         nxt_width = period_ff >> 1;
      if (nxt_width == {CW{1'b0}})
         nxt_width = {{(CW-1){1'b0}}, 1'b1};
   end
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         period_ff   <= {CW{1'b1}};
         last_per_ff <= {CW{1'b0}};
         width_ff    <= {CW{1'b0}};
         run_ff      <= 1'b0;
      end else if (i_event) begin
         period_ff   <= {CW{1'b0}};
         last_per_ff <= period_ff;
         width_ff    <= nxt_width;
         run_ff      <= 1'b1;
      end else begin
         if (period_ff != {CW{1'b1}})
            period_ff <= period_ff + {{(CW-1){1'b0}}, 1'b1};
         if (run_ff) begin
            width_ff <= width_ff - {{(CW-1){1'b0}}, 1'b1};
            if (width_ff == {{(CW-1){1'b0}}, 1'b1})
               run_ff <= 1'b0;
         end
      end
   end
   assign o_active = run_ff;
endmodule

// file: design/epfo_top.v
// Function
// - Multiply channels, filter, convert power to rate
// - Slow outputs pulse low, idle high
// - Base rate is oscillator over selected power-of-two
// - Slow rate follows the transfer equation scaling
// - Full-scale slow rate is 0.204 base rate
// - Scale pin high gives 128/64/32/16 multiples
// - Scale pin low gives 64/32/16 or 2048
// - Slow outputs average over long accumulation
// - Calibration output uses short accumulation
// - Slow outputs alternate, half period below 1062ms
// - Calibration pulse 173ms high, half when short
// - High-rate mode pulse fixed at 35us
// - Below 0.0014 percent base rate, no pulses
`include "epfo_consts.vh"
module epfo_top #(
   parameter SW  = 16,
   parameter PW  = 32,
   // Accumulator holds 2^(PW-2+19) plus one step
   parameter AW  = 52,
   parameter CW  = 28,
   parameter LPF = 12
) (
   // Clock and reset
   input  wire                 i_clock,
   input  wire                 i_nrst,
   // Channel samples, one per sample strobe
   input  wire                 i_sample_valid,
   input  wire signed [SW-1:0] i_current_channel,
   input  wire signed [SW-1:0] i_voltage_channel,
   // Select pins
   input  wire                 i_rate_sel_lo,
   input  wire                 i_rate_sel_hi,
   input  wire                 i_cal_scale_sel,
   // Pulse outputs
   output wire                 o_slow_pulse_a,
   output wire                 o_slow_pulse_b,
   output wire                 o_cal_pulse_out
);
   // Pin synchronisers: change counts once stages two and three agree
   reg  [2:0]        s1_ff;
   reg  [2:0]        s2_ff;
   reg  [2:0]        s3_ff;
   reg  [2:0]        sel_ff;
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_ff  <= 3'h0;
         s2_ff  <= 3'h0;
         s3_ff  <= 3'h0;
         sel_ff <= 3'h0;
      end else begin
         s1_ff <= {i_cal_scale_sel, i_rate_sel_hi, i_rate_sel_lo};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            sel_ff <= s3_ff;
      end
   end
   wire [1:0] rsel  = sel_ff[1:0];
   wire       scale = sel_ff[2];
   wire       hi_rate = !scale && (rsel == 2'h3);
   // Constants narrowed once here so no assignment truncates
   localparam [5:0]    EXP_00      = `EPFO_DIV_EXP_00;
   localparam [5:0]    EXP_01      = `EPFO_DIV_EXP_01;
   localparam [5:0]    EXP_10      = `EPFO_DIV_EXP_10;
   localparam [5:0]    EXP_11      = `EPFO_DIV_EXP_11;
   localparam [5:0]    FS_EXP      = PW - 2;
   localparam [4:0]    LOG_128     = `EPFO_CAL_LOG_128;
   localparam [4:0]    LOG_HR      = `EPFO_CAL_LOG_HR;
   localparam [AW-1:0] FS_MILLI    = `EPFO_FS_MILLI;
   localparam [AW-1:0] CREEP_PP10M = `EPFO_CREEP_PP10M;
   localparam [AW-1:0] ONE         = {{(AW-1){1'b0}}, 1'b1};
   // Product and one-pole low-pass filter
   reg signed [PW-1:0] prod_ff;
   reg signed [PW-1:0] lpf_ff;
   reg                 pv_ff;
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         prod_ff <= {PW{1'b0}};
         lpf_ff  <= {PW{1'b0}};
         pv_ff   <= 1'b0;
      end else begin
         pv_ff <= i_sample_valid;
         if (i_sample_valid)
            prod_ff <= i_current_channel * i_voltage_channel;
         if (pv_ff)
            lpf_ff <= lpf_ff + ((prod_ff - lpf_ff) >>> LPF);
      end
   end
   // Negative power makes no pulses; reverse indication is not built
   wire [PW-1:0] power = lpf_ff[PW-1] ? {PW{1'b0}} : lpf_ff;
   // Full scale power (2^(PW-2)) gives 0.204 of the base rate: each clock
   // adds 0.204 of the power and the slow threshold is 2^(PW-2+exp).
   function [5:0] base_exp;
      input [1:0] code;
      begin
         case (code)
            2'h0:    base_exp = EXP_00;
            2'h1:    base_exp = EXP_01;
            2'h2:    base_exp = EXP_10;
            default: base_exp = EXP_11;
         endcase
      end
   endfunction
   function [4:0] cal_log;
      input [1:0] code;
      input       sc;
      begin
         if (!sc && code == 2'h3)
            cal_log = LOG_HR;
         else
            cal_log = LOG_128 - {3'h0, code} - {4'h0, ~sc};
      end
   endfunction
   // Accumulator step: add the power, take the threshold off on a crossing
   // The remainder carries over, so no energy is lost between pulses
   function [AW-1:0] acc_next;
      input [AW-1:0] acc;
      input [AW-1:0] add;
      input [AW-1:0] thr;
      begin
         if (acc + add >= thr)
            acc_next = acc + add - thr;
         else
            acc_next = acc + add;
      end
   endfunction
   function acc_cross;
      input [AW-1:0] acc;
      input [AW-1:0] add;
      input [AW-1:0] thr;
      begin
         acc_cross = (acc + add >= thr);
      end
   endfunction
   wire [AW-1:0] scaled   = ({{(AW-PW){1'b0}}, power} * FS_MILLI) / 1000;
   wire [5:0]    sh_slow  = base_exp(rsel) + FS_EXP;
   wire [5:0]    sh_cal   = sh_slow - {1'b0, cal_log(rsel, scale)};
   wire [AW-1:0] thr_slow = ONE << sh_slow;
   wire [AW-1:0] thr_cal  = ONE << sh_cal;
   // Creep: below 0.0014 percent of the base rate nothing accumulates
   wire [AW-1:0] creep     = {{(AW-PW){1'b0}}, power} * 10000000;
   wire [AW-1:0] creep_lim = (ONE << FS_EXP) * CREEP_PP10M * 1000 / 204;
   wire          no_load   = creep < creep_lim;
   // Energy accumulators keep their remainders
   reg  [AW-1:0] acc_slow_ff;
   reg  [AW-1:0] acc_cal_ff;
   reg           ev_slow_ff;
   reg           ev_cal_ff;
   reg           phase_ff;
   wire          cross_slow = acc_cross(acc_slow_ff, scaled, thr_slow);
   wire          cross_cal  = acc_cross(acc_cal_ff, scaled, thr_cal);
   // Long accumulation averages the double-line-frequency ripple
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_slow_ff <= {AW{1'b0}};
         ev_slow_ff  <= 1'b0;
         phase_ff    <= 1'b0;
      end else begin
         ev_slow_ff <= 1'b0;
         if (!no_load) begin
            acc_slow_ff <= acc_next(acc_slow_ff, scaled, thr_slow);
            ev_slow_ff  <= cross_slow;
         end
         // Phase flips after the event so that line a takes the first pulse
         if (ev_slow_ff)
            phase_ff <= ~phase_ff;
      end
   end
   // Short accumulation lets the calibration rate follow the ripple
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_cal_ff <= {AW{1'b0}};
         ev_cal_ff  <= 1'b0;
      end else begin
         ev_cal_ff <= 1'b0;
         if (!no_load) begin
            acc_cal_ff <= acc_next(acc_cal_ff, scaled, thr_cal);
            ev_cal_ff  <= cross_cal;
         end
      end
   end
   // Pulse shaping
   wire a_act;
   wire b_act;
   wire c_act;
   localparam [CW-1:0] SLOW_CAP = `EPFO_SLOW_MAX_CYC / 2;
   localparam [CW-1:0] CAL_CAP  = `EPFO_CAL_WIDTH_CYC;
   localparam [CW-1:0] HR_CAP   = `EPFO_HR_WIDTH_CYC;
   epfo_pulse_shaper #(.CW(CW)) u_a (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_event (ev_slow_ff && !phase_ff),
      .i_cap   (SLOW_CAP),
      .i_fixed (1'b0),
      .o_active(a_act)
   );
   epfo_pulse_shaper #(.CW(CW)) u_b (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_event (ev_slow_ff && phase_ff),
      .i_cap   (SLOW_CAP),
      .i_fixed (1'b0),
      .o_active(b_act)
   );
   epfo_pulse_shaper #(.CW(CW)) u_c (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .i_event (ev_cal_ff),
      .i_cap   (hi_rate ? HR_CAP : CAL_CAP),
      .i_fixed (hi_rate),
      .o_active(c_act)
   );
   // Each alternate output sees every other pulse; half of its own period
   // (two slow periods) is one slow period, a trade kept for simplicity.
   assign o_slow_pulse_a  = ~a_act;
   assign o_slow_pulse_b  = ~b_act;
   assign o_cal_pulse_out = c_act;
endmodule

// file: verification/epfo_checker_properties.sv
`include "epfo_consts.vh"
module epfo_checker (
   // Clock and reset
   input wire logic        i_clock,
   input wire logic        i_nrst,
   // Samples and pins
   input wire logic        i_sample_valid,
   input wire logic [15:0] i_current_channel,
   input wire logic [15:0] i_voltage_channel,
   input wire logic        i_rate_sel_lo,
   input wire logic        i_rate_sel_hi,
   input wire logic        i_cal_scale_sel,
   // Pulse outputs
   input wire logic        o_slow_pulse_a,
   input wire logic        o_slow_pulse_b,
   input wire logic        o_cal_pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] high_ff;
   logic        pos_ff, a_last_ff;
   wire logic   hr = !i_cal_scale_sel && i_rate_sel_hi && i_rate_sel_lo;
   // Zero or opposite-sign samples never give positive power
   wire logic   pos = i_sample_valid && |i_current_channel && |i_voltage_channel
                      && (i_current_channel[15] == i_voltage_channel[15]);
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         high_ff <= 16'h0000;
         pos_ff <= 1'b0;
         a_last_ff <= 1'b0;
      end else begin
         high_ff <= o_cal_pulse_out ? high_ff + 16'h0001 : 16'h0000;
         pos_ff <= pos_ff || pos;
         if ($fell(o_slow_pulse_a)) a_last_ff <= 1'b1;
         if ($fell(o_slow_pulse_b)) a_last_ff <= 1'b0;
      end
   end
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   sequence s_hr_rise;
      hr && $rose(o_cal_pulse_out);
   endsequence
   sequence s_hr_fall;
      hr && $fell(o_cal_pulse_out);
   endsequence
   AST_SLOW_RESET_IDLE: assert property (disable iff (1'b0)
      !i_nrst && !$past(i_nrst) |-> o_slow_pulse_a && o_slow_pulse_b)
      else $error("slow line low in reset");
   AST_CAL_RESET_LOW: assert property (disable iff (1'b0)
      !i_nrst && !$past(i_nrst) |-> !o_cal_pulse_out) else $error("cal line high in reset");
   AST_SLOW_NEVER_BOTH: assert property (
      o_slow_pulse_a || o_slow_pulse_b) else $error("both slow lines low");
   AST_SLOW_A_TURN: assert property (
      $fell(o_slow_pulse_a) |-> !a_last_ff) else $error("slow a pulsed twice");
   AST_SLOW_B_TURN: assert property (
      $fell(o_slow_pulse_b) |-> a_last_ff) else $error("slow b out of turn");
   AST_HR_WIDTH: assert property (
      s_hr_fall |-> high_ff == `EPFO_HR_WIDTH_CYC) else $error("high-rate width wrong");
   AST_HR_HOLD: assert property (
      s_hr_rise |-> o_cal_pulse_out [*8]) else $error("high-rate pulse too short");
   AST_CREEP_NONE: assert property (
      !pos_ff |-> o_slow_pulse_a && o_slow_pulse_b && !o_cal_pulse_out)
      else $error("pulse without positive power");
endmodule
bind epfo_top epfo_checker i_chk (.i_clock(i_clock), .i_nrst(i_nrst),
   .i_sample_valid(i_sample_valid), .i_current_channel(i_current_channel),
   .i_voltage_channel(i_voltage_channel), .i_rate_sel_lo(i_rate_sel_lo),
   .i_rate_sel_hi(i_rate_sel_hi), .i_cal_scale_sel(i_cal_scale_sel),
   .o_slow_pulse_a(o_slow_pulse_a), .o_slow_pulse_b(o_slow_pulse_b),
   .o_cal_pulse_out(o_cal_pulse_out));

// file: verification/epfo_counter_model.sv
// Pulse counter on the calibration line, as a meter counter input sees it
module epfo_counter_model (
   // Clock and clear
   input  wire logic        i_clock,
   input  wire logic        i_clear,
   // Pulse line
   input  wire logic        i_cal,
   // Tallies
   output logic      [15:0] o_count,
   output logic      [15:0] o_width
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] run_ff = 16'h0000;
   logic        cal_ff = 1'b0;
   // Counts leading edges only, so a long pulse is one unit
   always @(posedge i_clock) begin
      cal_ff <= i_cal;
      run_ff <= i_cal ? run_ff + 16'h0001 : 16'h0000;
      if (i_clear) o_count <= 16'h0000;
      else if (i_cal && !cal_ff) o_count <= o_count + 16'h0001;
      if (!i_cal && cal_ff) o_width <= run_ff;
   end
endmodule

// file: verification/energy_pulse_freq_output_tb.sv
`include "epfo_consts.vh"
module energy_pulse_freq_output_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk = 1'b0, nrst = 1'b0, clr = 1'b1;
   logic               sel_l = 1'b0, sel_h = 1'b0, scale = 1'b0;
   logic signed [15:0] cur = 16'h0000, vol = 16'h0000;
   wire logic          a, b, cal;
   logic        [15:0] n_cal, w_cal;
   int                 err_count = 0, total_checks = 0, cyc = 0;
   always #50 clk = ~clk;
   epfo_top i_dut (.i_clock(clk), .i_nrst(nrst), .i_sample_valid(1'b1),
      .i_current_channel(cur), .i_voltage_channel(vol), .i_rate_sel_lo(sel_l),
      .i_rate_sel_hi(sel_h), .i_cal_scale_sel(scale), .o_slow_pulse_a(a),
      .o_slow_pulse_b(b), .o_cal_pulse_out(cal));
   epfo_counter_model i_meter (.i_clock(clk), .i_clear(clr), .i_cal(cal),
      .o_count(n_cal), .o_width(w_cal));
   task complete_run;
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input string nm, input int ex, input logic [15:0] got, input int tol);
      total_checks++;
      if ($isunknown(got) || got + tol < ex || got > ex + tol) begin
         err_count++;
         $display("wrong value %s expected %0d seen %0d", nm, ex, got);
      end
   endtask
   // Pins move only under reset, since a rate-select change rescales every output at once
   task run(input logic h, l, s, input logic signed [15:0] c, v, input int n);
      nrst <= 1'b0;
      clr <= 1'b1;
      {sel_h, sel_l, scale} <= {h, l, s};
      cur <= c;
      vol <= v;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (n) @(posedge clk);
      clr <= 1'b0;
   endtask
   task t_zero_power;
      run(1'b0, 1'b0, 1'b0, 16'sh0000, 16'sh0000, 0);
      repeat (3000) @(posedge clk);
      check("cal pulses", 0, n_cal, 0);
      check("slow a level", 1, {15'h0000, a}, 0);
   endtask
   task t_negative_power;
      run(1'b1, 1'b1, 1'b0, 16'sh4000, -16'sh4000, 0);
      repeat (5000) @(posedge clk);
      check("cal pulses", 0, n_cal, 0);
      check("slow b level", 1, {15'h0000, b}, 0);
   endtask
   task t_high_rate;
      run(1'b1, 1'b1, 1'b0, 16'sh4000, 16'sh4000, 30000);
      repeat (20000) @(posedge clk);
      // Quarter scale: 0.204/4 of the base rate, times 2048, over 20000 cycles
      check("cal pulses", $rtoi(0.051 * 2048.0 * 20000.0 / 65536.0 + 0.5), n_cal, 2);
      check("cal width", `EPFO_HR_WIDTH_CYC, w_cal, 0);
      check("slow a level", 1, {15'h0000, a}, 0);
   endtask
   initial begin
      @(posedge clk);
      t_zero_power();
      t_negative_power();
      t_high_rate();
      complete_run();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         err_count++;
         complete_run();
      end
   end
endmodule
